// file: dac_serial_write_port_bench.sv
// Purpose: self-checking bench for the serial write port
// Assumes: strobe and reset driven on the falling system clock edge
// Notes: outputs are compared as the 15 low bits of the last taken word
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module dac_serial_write_port_bench;
  logic ref_clk, reset_n, strobe_n, buf_q, gain_n, active, pending;
  wire sclk, cs_n, sdata;
  logic [11:0] code;
  wire [14:0] outs = {buf_q, gain_n, active, code};
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;

  dsw_host_model i_host (.serial_clk_o(sclk), .chip_select_n_o(cs_n),
    .serial_data_o(sdata));
  dsw_write_port #(.CODE_BITS(12)) i_dut (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
    .serial_clk_i(sclk), .chip_select_n_i(cs_n), .serial_data_i(sdata),
    .load_output_strobe_n_i(strobe_n), .ref_buffered_o(buf_q),
    .gain_select_n_o(gain_n), .output_active_o(active),
    .converter_code_o(code), .pending_o(pending));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic end_sim;
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // a hang is cut short well past the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic frame(input logic [19:0] w, input int n, input logic cpol);
    i_host.send(w, n, cpol);
    repeat (10) @(negedge ref_clk);
  endtask

  task automatic pulse;
    strobe_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    strobe_n = 1'b1;
    repeat (3) @(negedge ref_clk);
  endtask

  initial begin
    reset_n = 1'b0;
    strobe_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK(outs, 15'h0000)
    `CHK(pending, 1'b0)
    frame({16'h7ABC, 4'h0}, 16, 1'b1);
    `CHK(outs, 15'h0000)
    `CHK(pending, 1'b1)
    pulse();
    `CHK(outs, 15'h7ABC)
    `CHK(pending, 1'b0)
    // strobe held low from here on
    strobe_n = 1'b0;
    frame({16'hF123, 4'h0}, 16, 1'b0);
    `CHK(outs, 15'h7ABC)
    frame({16'h1555, 4'h0}, 10, 1'b0);
    `CHK(outs, 15'h7ABC)
    frame({16'h1234, 4'hF}, 20, 1'b0);
    `CHK(outs, 15'h1234)
    frame({16'h0FFF, 4'h0}, 16, 1'b1);
    `CHK(outs, 15'h0FFF)
    frame({16'h1001, 4'h0}, 16, 1'b0);
    `CHK(outs, 15'h1001)
    reset_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK(outs, 15'h0000)
    end_sim();
  end
endmodule
`default_nettype wire

// file: dsw_frame_rx.sv
// Purpose: link-clock side shift register and bit counter for one command frame
// Assumes: link clock idle or running only around frames; chip select is async to it
// Notes: hands a completed word to the system domain by a toggle
`timescale 1ns/1ps
`default_nettype none
module dsw_frame_rx
  import dsw_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic chip_select_n_i,
  input wire logic serial_data_i,
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  output logic [DSW_WORD_BITS-1:0] word_o,
  output logic word_toggle_o
);
  logic [DSW_WORD_BITS-1:0] shift;
  logic [DSW_CNT_BITS-1:0] bit_cnt;
  logic full;
  logic cs_meta;
  logic cs_sync;
  logic cs_last;

  // frame counter is held clear by chip select high, so each frame starts at zero
  always_ff @(posedge link_clk_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      bit_cnt <= '0; // [R20] [R09]
    end else if (bit_cnt != DSW_WORD_COUNT) begin
      bit_cnt <= bit_cnt + 5'h01; // [R06]
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (!chip_select_n_i && bit_cnt != DSW_WORD_COUNT) begin
      shift <= {shift[DSW_WORD_BITS-2:0], serial_data_i}; // [R02] [R05]
    end
  end

  // completion flag survives the select rise that clears the counter; it restarts at the
  // first clock of the next frame, so a frame cut short never reports complete
  // limitation: a select pulse with no clock at all re-offers the previous word unchanged
  always_ff @(posedge link_clk_i) begin
    if (!chip_select_n_i) begin
      full <= (bit_cnt >= DSW_WORD_COUNT - 5'h01); // [R07] [R08]
    end
  end

  chk_count_cap: assert property (@(posedge link_clk_i) disable iff (chip_select_n_i) // [R06]
    bit_cnt <= DSW_WORD_COUNT)
    else $error("frame bit counter ran past a full word");

  // the link clock stops after the frame, so the frame end is seen in the system domain
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_meta <= 1'h1;
      cs_sync <= 1'h1;
      cs_last <= 1'h1;
    end else begin
      cs_meta <= chip_select_n_i;
      cs_sync <= cs_meta;
      cs_last <= cs_sync;
    end
  end

  // flag and shift are stable once chip select is high and the clock is still
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      word_o <= DSW_RST_WORD;
      word_toggle_o <= 1'h0;
    end else if (cs_sync && !cs_last && full) begin
      word_o <= shift; // [R07]
      word_toggle_o <= !word_toggle_o;
    end
  end
endmodule
`default_nettype wire

// file: dsw_host_model.sv
// Purpose: host spi master model that sends command frames to the write port
// Assumes: link clock period 48 ns, running only inside frames
// Notes: data line shows the inverse of its last bit once released
`timescale 1ns/1ps
`default_nettype none
module dsw_host_model (
  output logic serial_clk_o,
  output logic chip_select_n_o,
  output logic serial_data_o
);
  // select settles high just after power-up; that rise clears the frame counter
  initial begin
    serial_clk_o = 1'b0;
    chip_select_n_o = 1'b0;
    serial_data_o = 1'b0;
    #1 chip_select_n_o = 1'b1;
  end
  // w is msb aligned; n bits are clocked, data changes on the falling edge
  task automatic send(input logic [19:0] w, input int n, input logic cpol);
    serial_clk_o = cpol;
    #30 chip_select_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_clk_o = 1'b0;
      serial_data_o = w[19-i];
      #24 serial_clk_o = 1'b1;
      #24;
    end
    serial_clk_o = cpol;
    #24 chip_select_n_o = 1'b1;
    serial_data_o = ~serial_data_o;
    // select stays high well over 100 ns with the clock still
    #150;
  endtask
endmodule
`default_nettype wire

// file: dsw_pkg.sv
// Purpose: shared constants for the serial write port of the voltage-output converter
// Assumes: 16-bit command words, msb first
// Notes: field positions and reset values of the command word
package dsw_pkg;
  localparam int unsigned DSW_WORD_BITS = 16;
  localparam int unsigned DSW_CODE_BITS = 12;
  localparam int unsigned DSW_CNT_BITS = 5;
  localparam logic [4:0] DSW_WORD_COUNT = 5'h10;
  localparam int unsigned DSW_IGNORE_BIT = 15;
  localparam int unsigned DSW_BUF_BIT = 14;
  localparam int unsigned DSW_GAIN_BIT = 13;
  localparam int unsigned DSW_ACTIVE_BIT = 12;
  localparam int unsigned DSW_CODE_MSB = 11;
  localparam logic DSW_RST_BUF = 1'h0;
  localparam logic DSW_RST_GAIN_N = 1'h0;
  localparam logic DSW_RST_ACTIVE = 1'h0;
  localparam logic [11:0] DSW_RST_CODE = 12'h000;
  localparam logic [15:0] DSW_RST_WORD = 16'h0000;
endpackage

// file: dsw_write_port.sv
// Purpose: receive-only serial command port with input and output registers
// Assumes: host spi master in mode 0,0 or 1,1; load strobe from host logic
// Notes: reset_n_i stands for the internal power-on reset
//
// Contract
// R01 - works with spi modes 0,0 and 1,1
// R02 - sample data on rising serial clock
// R03 - receive only, nothing read back
// R04 - host holds select low whole command
// R05 - sixteen bits msb first, 4 config 12 code
// R06 - clocks past sixteenth are ignored
// R07 - select rise after sixteen latches input register
// R08 - early select rise aborts, register unchanged
// R09 - select high ignores clock and data
// R10 - load strobe low copies to output
// R11 - top bit one discards the command
// R12 - bit 14 selects buffered reference
// R13 - bit 13 one gives unity gain
// R14 - bit 12 one is active, zero powers down
// R15 - code left aligned in bits 11..0
// R16 - starts powered down, output high impedance
// R17 - reset state holds until next write
// R18 - port works in power-down, bit 12 exits
// R19 - host may tie load strobe low
// R20 - bit counter clears on select fall; the code clears it on select rise and holds it clear while select is high
// R21 - strobe high keeps output register unchanged
`timescale 1ns/1ps
`default_nettype none
module dsw_write_port
  import dsw_pkg::*;
#(
  parameter int unsigned CODE_BITS = DSW_CODE_BITS
)
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic serial_clk_i,
  input wire logic chip_select_n_i,
  input wire logic serial_data_i,
  input wire logic load_output_strobe_n_i,
  output logic ref_buffered_o,
  output logic gain_select_n_o,
  output logic output_active_o,
  output logic [DSW_CODE_BITS-1:0] converter_code_o,
  output logic pending_o
);
  // no serial output pin exists [R03]
  logic [DSW_WORD_BITS-1:0] rx_word;
  logic rx_toggle;
  logic tog_meta;
  logic tog_sync;
  logic tog_last;
  logic ld_meta;
  logic ld_sync;
  logic in_buf;
  logic in_gain_n;
  logic in_active;
  logic [DSW_CODE_BITS-1:0] in_code;
  logic word_new;
  logic write_ok;

  // modes 0,0 and 1,1 both sample on the rising edge, so one receiver serves both [R01]
  dsw_frame_rx u_rx (
    .link_clk_i(serial_clk_i),
    .chip_select_n_i(chip_select_n_i),
    .serial_data_i(serial_data_i),
    .sys_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .word_o(rx_word),
    .word_toggle_o(rx_toggle)
  );

  function automatic logic [DSW_CODE_BITS-1:0] mask_code(input logic [DSW_CODE_BITS-1:0] c);
    logic [DSW_CODE_BITS-1:0] m;
    m = '0;
    for (int i = 0; i < DSW_CODE_BITS; i++) begin
      m[i] = (i >= DSW_CODE_BITS - CODE_BITS);
    end
    mask_code = c & m; // [R15]
  endfunction

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tog_meta <= 1'h0;
      tog_sync <= 1'h0;
      tog_last <= 1'h0;
      ld_meta <= 1'h1;
      ld_sync <= 1'h1;
    end else begin
      tog_meta <= rx_toggle;
      tog_sync <= tog_meta;
      tog_last <= tog_sync;
      ld_meta <= load_output_strobe_n_i;
      ld_sync <= ld_meta;
    end
  end

  assign word_new = tog_sync ^ tog_last;
  assign write_ok = word_new && !rx_word[DSW_IGNORE_BIT]; // [R11]

  // input register; an aborted frame with at least one clock never toggles, so it stays as it was [R08]
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_buf <= DSW_RST_BUF;
      in_gain_n <= DSW_RST_GAIN_N;
      in_active <= DSW_RST_ACTIVE;
      in_code <= DSW_RST_CODE;
    end else if (write_ok) begin
      in_buf <= rx_word[DSW_BUF_BIT]; // [R12]
      in_gain_n <= rx_word[DSW_GAIN_BIT]; // [R13]
      in_active <= rx_word[DSW_ACTIVE_BIT]; // [R14] [R18]
      in_code <= mask_code(rx_word[DSW_CODE_MSB:0]); // [R07]
    end
  end

  // marks a written input register not yet moved to the output
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pending_o <= 1'h0; // [R17]
    end else if (write_ok) begin
      pending_o <= 1'h1; // write beats the transfer that clears it
    end else if (!ld_sync) begin
      pending_o <= 1'h0;
    end
  end

  // output register; the held-low strobe case updates a cycle after the write [R19]
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ref_buffered_o <= DSW_RST_BUF;
      gain_select_n_o <= DSW_RST_GAIN_N;
      output_active_o <= DSW_RST_ACTIVE; // [R16] [R17]
      converter_code_o <= DSW_RST_CODE;
    end else if (!ld_sync) begin
      ref_buffered_o <= in_buf; // [R10]
      gain_select_n_o <= in_gain_n;
      output_active_o <= in_active;
      converter_code_o <= in_code;
    end
  end // strobe high holds the output register [R21]

  chk_ignored_word: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R11]
    word_new && rx_word[DSW_IGNORE_BIT] |=> $stable(in_code) && $stable(in_active))
    else $error("ignored command changed input register");
  chk_write_lands: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R07]
    write_ok |=> in_active == $past(rx_word[DSW_ACTIVE_BIT]) &&
    in_buf == $past(rx_word[DSW_BUF_BIT]))
    else $error("write did not reach input register");
  chk_gain_bit: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R13]
    write_ok |=> in_gain_n == $past(rx_word[DSW_GAIN_BIT]))
    else $error("gain bit not latched");
  chk_strobe_copy: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R10]
    !ld_sync |=> converter_code_o == $past(in_code) && output_active_o == $past(in_active))
    else $error("strobe low did not copy input register");
  chk_config_copy: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R10]
    !ld_sync |=> ref_buffered_o == $past(in_buf) && gain_select_n_o == $past(in_gain_n))
    else $error("strobe low did not copy configuration bits");
  chk_strobe_hold: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R21]
    ld_sync |=> $stable(converter_code_o) && $stable(output_active_o))
    else $error("output changed with strobe high");
  chk_config_hold: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R21]
    ld_sync |=> $stable(ref_buffered_o) && $stable(gain_select_n_o))
    else $error("configuration outputs changed with strobe high");
  chk_no_spurious: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R08]
    !word_new |=> $stable(in_code) && $stable(in_buf))
    else $error("input register changed without a frame");
  chk_stay_down: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R18]
    !output_active_o && !in_active |=> !output_active_o)
    else $error("left power-down without a latched active bit");
  chk_pending_set: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R17]
    write_ok |=> pending_o [*1] ##1 (pending_o || !ld_sync || $past(!ld_sync)))
    else $error("pending flag lost after write");
  chk_pending_clear: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R10]
    !write_ok && !ld_sync |=> !pending_o)
    else $error("pending flag kept after transfer");
  chk_low_code: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R15]
    word_new |=> (in_code & ~mask_code({DSW_CODE_BITS{1'b1}})) == '0)
    else $error("ignored low code bits stored");

  cov_write: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) write_ok);
  cov_ignore: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    word_new && rx_word[DSW_IGNORE_BIT]);
  cov_wake: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) $rose(output_active_o));
  cov_held: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) write_ok && ld_sync);
endmodule
`default_nettype wire
